// File: core/nibble_core_pkg.sv
// Shared constants, opcodes and state types of the nibble execution core
`default_nettype none
package nibble_core_pkg;
    localparam int NIB_W = 4;
    localparam int E_W = 8;
    localparam int D_W = 3;
    localparam int Z_W = 2;
    localparam int PTR_W = 10;
    localparam int PC_W = 14;
    localparam int PAGE_W = 7;
    localparam int OFF_W = 7;
    localparam int STK_DEPTH = 8;
    localparam int STK_IDX_W = 3;
    localparam int ROM_W = 8;
    localparam int ROM_HI_LSB = 4;
    localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
    localparam logic [E_W-1:0] E_RST = 8'h00;
    localparam logic [D_W-1:0] D_RST = 3'h0;
    localparam logic [Z_W-1:0] Z_RST = 2'h0;
    localparam logic [PC_W-1:0] PC_RST = 14'h0000;
    localparam logic [STK_IDX_W-1:0] STK_IDX_RST = 3'h0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
    localparam logic [STK_IDX_W-1:0] STK_STEP = 3'h1;
    localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;

    typedef enum logic [5:0] {
        op_nop,
        copy_b_to_acc,
        copy_y_to_acc,
        copy_acc_to_y,
        pack_e_from_b_acc,
        unpack_e_to_b_acc,
        load_d_from_acc,
        read_d_to_acc,
        read_z_to_acc,
        read_stack_index,
        rom_lookup_fetch,
        load_pointer_xy,
        load_pointer_bank,
        pointer_inc,
        pointer_dec,
        mem_to_acc_load,
        acc_mem_swap,
        swap_then_dec,
        swap_then_inc,
        add_mem_to_acc,
        add_mem_with_carry,
        add_acc_immediate,
        load_acc_immediate,
        and_mem_to_acc,
        or_mem_to_acc,
        set_carry_op,
        clear_carry_op,
        skip_if_carry_zero,
        invert_acc,
        rotate_right_thru_carry,
        return_op,
        return_skip_op
    } op_t;

    typedef enum logic [2:0] {
        alu_add,
        alu_and,
        alu_or,
        alu_not,
        alu_rar
    } alu_op_t;

    typedef enum logic [1:0] {
        ph_run,
        ph_lookup_data,
        ph_pop
    } phase_t;
endpackage : nibble_core_pkg
`default_nettype wire

// File: core/core_link_if.sv
// Links between the core, its arithmetic unit and its return stack
`timescale 1ns/10ps
`default_nettype none
interface core_link_if;
    logic [nibble_core_pkg::NIB_W-1:0] alu_a;
    logic [nibble_core_pkg::NIB_W-1:0] alu_b;
    logic alu_cin;
    nibble_core_pkg::alu_op_t alu_op;
    logic [nibble_core_pkg::NIB_W-1:0] alu_y;
    logic alu_cout;
    logic stk_we;
    logic [nibble_core_pkg::STK_IDX_W-1:0] stk_widx;
    logic [nibble_core_pkg::STK_IDX_W-1:0] stk_ridx;
    logic [nibble_core_pkg::PC_W-1:0] stk_wdata;
    logic [nibble_core_pkg::PC_W-1:0] stk_rdata;
    modport core (
        output alu_a, alu_b, alu_cin, alu_op, stk_we, stk_widx, stk_ridx,
        output stk_wdata,
        input alu_y, alu_cout, stk_rdata
    );
    modport alu (
        input alu_a, alu_b, alu_cin, alu_op,
        output alu_y, alu_cout
    );
    modport stack (
        input stk_we, stk_widx, stk_ridx, stk_wdata,
        output stk_rdata
    );
endinterface : core_link_if
`default_nettype wire

// File: core/nibble_alu.sv
// Four-bit arithmetic and logic unit with carry
`timescale 1ns/10ps
`default_nettype none
module nibble_alu (
    core_link_if.alu lnk
);
    logic [nibble_core_pkg::NIB_W:0] sum;

    always_comb begin
        sum = {1'b0, lnk.alu_a} + {1'b0, lnk.alu_b} + {4'h0, lnk.alu_cin};
        lnk.alu_y = sum[nibble_core_pkg::NIB_W-1:0];
        lnk.alu_cout = lnk.alu_cin;
        case (lnk.alu_op)
            nibble_core_pkg::alu_add: begin
                lnk.alu_cout = sum[nibble_core_pkg::NIB_W];
            end
            nibble_core_pkg::alu_and: begin
                lnk.alu_y = lnk.alu_a & lnk.alu_b;
            end
            nibble_core_pkg::alu_or: begin
                lnk.alu_y = lnk.alu_a | lnk.alu_b;
            end
            nibble_core_pkg::alu_not: begin
                lnk.alu_y = ~lnk.alu_a;
            end
            nibble_core_pkg::alu_rar: begin
                lnk.alu_y = {lnk.alu_cin, lnk.alu_a[3:1]};
                lnk.alu_cout = lnk.alu_a[0];
            end
            default: begin
                lnk.alu_y = lnk.alu_a;
            end
        endcase
    end
endmodule : nibble_alu
`default_nettype wire

// File: core/return_stack_mem.sv
// Eight-entry return address store with registered read data
`timescale 1ns/10ps
`default_nettype none
module return_stack_mem (
    input wire logic clk,
    core_link_if.stack lnk
);
    logic [nibble_core_pkg::PC_W-1:0] mem [nibble_core_pkg::STK_DEPTH];
    logic [nibble_core_pkg::PC_W-1:0] rdata;

    assign lnk.stk_rdata = rdata;

    always_ff @(posedge clk) begin
        if (lnk.stk_we) begin
            mem[lnk.stk_widx] <= lnk.stk_wdata;
        end
        rdata <= mem[lnk.stk_ridx];
    end
endmodule : return_stack_mem
`default_nettype wire

// File: core/nibble_cpu_transfer_alu_ops.sv
// Execution datapath for transfer, pointer, lookup and arithmetic operations
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_transfer_alu_ops (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire nibble_core_pkg::op_t op_code,
    input wire logic [3:0] op_imm,
    input wire logic [3:0] op_imm2,
    input wire logic [6:0] op_page,
    input wire logic [3:0] ram_rdata,
    input wire logic [7:0] rom_rdata,
    output logic [9:0] ram_raddr,
    output logic ram_we,
    output logic [9:0] ram_waddr,
    output logic [3:0] ram_wdata,
    output logic [13:0] rom_addr,
    output logic busy,
    output logic skip_pending,
    output logic [3:0] acc,
    output logic [3:0] b,
    output logic [7:0] e,
    output logic [2:0] d,
    output logic [3:0] x,
    output logic [3:0] y,
    output logic [1:0] z,
    output logic carry_flag,
    output logic [13:0] pc,
    output logic [2:0] stack_index
);
    typedef struct packed {
        nibble_core_pkg::phase_t phase;
        logic busy;
        logic skip;
        logic pop_skip;
        logic [nibble_core_pkg::NIB_W-1:0] acc;
        logic [nibble_core_pkg::NIB_W-1:0] b;
        logic [nibble_core_pkg::E_W-1:0] e;
        logic [nibble_core_pkg::D_W-1:0] d;
        logic [nibble_core_pkg::NIB_W-1:0] x;
        logic [nibble_core_pkg::NIB_W-1:0] y;
        logic [nibble_core_pkg::Z_W-1:0] z;
        logic carry;
        logic [nibble_core_pkg::PC_W-1:0] pc;
        logic [nibble_core_pkg::STK_IDX_W-1:0] stack_index;
        logic ram_we;
        logic [nibble_core_pkg::PTR_W-1:0] ram_waddr;
        logic [nibble_core_pkg::NIB_W-1:0] ram_wdata;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic [nibble_core_pkg::PTR_W-1:0] ram_pointer;
    logic [nibble_core_pkg::NIB_W-1:0] mem_val;

    core_link_if lnk ();

    nibble_alu i_nibble_alu (
        .lnk(lnk.alu)
    );

    return_stack_mem i_return_stack_mem (
        .clk(clk),
        .lnk(lnk.stack)
    );

    assign ram_pointer = {st.z, st.x, st.y};
    // Forward a pending write so a back-to-back read sees the new nibble
    assign mem_val = (st.ram_we && st.ram_waddr == ram_pointer) ?
                     st.ram_wdata : ram_rdata;

    always_comb begin
        next_st = st;
        next_st.ram_we = 1'b0;
        lnk.alu_a = st.acc;
        lnk.alu_b = mem_val;
        lnk.alu_cin = 1'b0;
        lnk.alu_op = nibble_core_pkg::alu_add;
        lnk.stk_we = 1'b0;
        lnk.stk_widx = st.stack_index + nibble_core_pkg::STK_STEP;
        lnk.stk_wdata = st.pc + nibble_core_pkg::PC_STEP;
        lnk.stk_ridx = st.stack_index;
        case (st.phase)
            nibble_core_pkg::ph_run: begin
                if (op_valid) begin
                    next_st.pc = st.pc + nibble_core_pkg::PC_STEP;
                    next_st.skip = 1'b0;
                    if (st.skip) begin
                        // Nullified slot, one cycle whatever it was
                        next_st.skip = 1'b0;
                    end else begin
                        case (op_code)
                            nibble_core_pkg::copy_b_to_acc: begin
                                next_st.acc = st.b;
                            end
                            nibble_core_pkg::copy_y_to_acc: begin
                                next_st.acc = st.y;
                            end
                            nibble_core_pkg::copy_acc_to_y: begin
                                next_st.y = st.acc;
                            end
                            nibble_core_pkg::pack_e_from_b_acc: begin
                                next_st.e = {st.b, st.acc};
                            end
                            nibble_core_pkg::unpack_e_to_b_acc: begin
                                next_st.b = st.e[7:4];
                                next_st.acc = st.e[3:0];
                            end
                            nibble_core_pkg::load_d_from_acc: begin
                                next_st.d = st.acc[2:0];
                            end
                            nibble_core_pkg::read_d_to_acc: begin
                                next_st.acc = {1'b0, st.d};
                            end
                            nibble_core_pkg::read_z_to_acc: begin
                                next_st.acc = {2'b00, st.z};
                            end
                            nibble_core_pkg::read_stack_index: begin
                                next_st.acc = {1'b0, st.stack_index};
                            end
                            nibble_core_pkg::rom_lookup_fetch: begin
                                lnk.stk_we = 1'b1;
                                next_st.stack_index = lnk.stk_widx;
                                next_st.pc = {op_page, st.d, st.acc};
                                next_st.phase = nibble_core_pkg::ph_lookup_data;
                            end
                            nibble_core_pkg::load_pointer_xy: begin
                                next_st.x = op_imm;
                                next_st.y = op_imm2;
                            end
                            nibble_core_pkg::load_pointer_bank: begin
                                next_st.z = op_imm[1:0];
                            end
                            nibble_core_pkg::pointer_inc: begin
                                next_st.y = st.y + nibble_core_pkg::NIB_ONE;
                            end
                            nibble_core_pkg::pointer_dec: begin
                                next_st.y = st.y - nibble_core_pkg::NIB_ONE;
                            end
                            nibble_core_pkg::mem_to_acc_load: begin
                                next_st.acc = mem_val;
                                next_st.x = st.x ^ op_imm;
                            end
                            nibble_core_pkg::acc_mem_swap,
                            nibble_core_pkg::swap_then_dec,
                            nibble_core_pkg::swap_then_inc: begin
                                next_st.acc = mem_val;
                                next_st.ram_we = 1'b1;
                                next_st.ram_waddr = ram_pointer;
                                next_st.ram_wdata = st.acc;
                                next_st.x = st.x ^ op_imm;
                                if (op_code == nibble_core_pkg::swap_then_dec) begin
                                    next_st.y = st.y - nibble_core_pkg::NIB_ONE;
                                end
                                if (op_code == nibble_core_pkg::swap_then_inc) begin
                                    next_st.y = st.y + nibble_core_pkg::NIB_ONE;
                                end
                            end
                            nibble_core_pkg::add_mem_to_acc: begin
                                next_st.acc = lnk.alu_y;
                            end
                            nibble_core_pkg::add_mem_with_carry: begin
                                lnk.alu_cin = st.carry;
                                next_st.acc = lnk.alu_y;
                                next_st.carry = lnk.alu_cout;
                            end
                            nibble_core_pkg::add_acc_immediate: begin
                                lnk.alu_b = op_imm;
                                next_st.acc = lnk.alu_y;
                            end
                            nibble_core_pkg::load_acc_immediate: begin
                                next_st.acc = op_imm;
                            end
                            nibble_core_pkg::and_mem_to_acc: begin
                                lnk.alu_op = nibble_core_pkg::alu_and;
                                next_st.acc = lnk.alu_y;
                            end
                            nibble_core_pkg::or_mem_to_acc: begin
                                lnk.alu_op = nibble_core_pkg::alu_or;
                                next_st.acc = lnk.alu_y;
                            end
                            nibble_core_pkg::set_carry_op: begin
                                next_st.carry = 1'b1;
                            end
                            nibble_core_pkg::clear_carry_op: begin
                                next_st.carry = 1'b0;
                            end
                            nibble_core_pkg::skip_if_carry_zero: begin
                                next_st.skip = ~st.carry;
                            end
                            nibble_core_pkg::invert_acc: begin
                                lnk.alu_op = nibble_core_pkg::alu_not;
                                next_st.acc = lnk.alu_y;
                            end
                            nibble_core_pkg::rotate_right_thru_carry: begin
                                lnk.alu_op = nibble_core_pkg::alu_rar;
                                lnk.alu_cin = st.carry;
                                next_st.acc = lnk.alu_y;
                                next_st.carry = lnk.alu_cout;
                            end
                            nibble_core_pkg::return_op,
                            nibble_core_pkg::return_skip_op: begin
                                next_st.pop_skip =
                                    (op_code == nibble_core_pkg::return_skip_op);
                                next_st.phase = nibble_core_pkg::ph_pop;
                            end
                            default: begin
                                next_st.acc = st.acc;
                            end
                        endcase
                    end
                end
            end
            nibble_core_pkg::ph_lookup_data: begin
                next_st.b = rom_rdata[nibble_core_pkg::ROM_W-1:
                                      nibble_core_pkg::ROM_HI_LSB];
                next_st.acc = rom_rdata[nibble_core_pkg::ROM_HI_LSB-1:0];
                next_st.pop_skip = 1'b0;
                next_st.phase = nibble_core_pkg::ph_pop;
            end
            nibble_core_pkg::ph_pop: begin
                next_st.pc = lnk.stk_rdata;
                next_st.stack_index = st.stack_index -
                                      nibble_core_pkg::STK_STEP;
                next_st.skip = st.pop_skip;
                next_st.pop_skip = 1'b0;
                next_st.phase = nibble_core_pkg::ph_run;
            end
            default: begin
                next_st.phase = nibble_core_pkg::ph_run;
            end
        endcase
        // Busy is its own flop so the port comes straight from a register
        next_st.busy = (next_st.phase != nibble_core_pkg::ph_run);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.phase <= nibble_core_pkg::ph_run;
            st.busy <= 1'b0;
            st.skip <= 1'b0;
            st.pop_skip <= 1'b0;
            st.acc <= nibble_core_pkg::NIB_RST;
            st.b <= nibble_core_pkg::NIB_RST;
            st.e <= nibble_core_pkg::E_RST;
            st.d <= nibble_core_pkg::D_RST;
            st.x <= nibble_core_pkg::NIB_RST;
            st.y <= nibble_core_pkg::NIB_RST;
            st.z <= nibble_core_pkg::Z_RST;
            st.carry <= nibble_core_pkg::CARRY_RST;
            st.pc <= nibble_core_pkg::PC_RST;
            st.stack_index <= nibble_core_pkg::STK_IDX_RST;
            st.ram_we <= 1'b0;
            st.ram_waddr <= {nibble_core_pkg::Z_RST, nibble_core_pkg::NIB_RST,
                             nibble_core_pkg::NIB_RST};
            st.ram_wdata <= nibble_core_pkg::NIB_RST;
        end else begin
            st <= next_st;
        end
    end

    assign ram_raddr = ram_pointer;
    assign ram_we = st.ram_we;
    assign ram_waddr = st.ram_waddr;
    assign ram_wdata = st.ram_wdata;
    assign rom_addr = st.pc;
    assign busy = st.busy;
    assign skip_pending = st.skip;
    assign acc = st.acc;
    assign b = st.b;
    assign e = st.e;
    assign d = st.d;
    assign x = st.x;
    assign y = st.y;
    assign z = st.z;
    assign carry_flag = st.carry;
    assign pc = st.pc;
    assign stack_index = st.stack_index;
endmodule : nibble_cpu_transfer_alu_ops
`default_nettype wire

// File: dv/nibble_core_assertions.sv
// Port checker of the nibble execution core
`timescale 1ns/10ps
`default_nettype none
module nibble_core_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire nibble_core_pkg::op_t op_code,
    input wire logic [6:0] op_page,
    input wire logic [3:0] ram_rdata,
    input wire logic [9:0] ram_raddr,
    input wire logic ram_we,
    input wire logic [9:0] ram_waddr,
    input wire logic [3:0] ram_wdata,
    input wire logic [13:0] rom_addr,
    input wire logic busy,
    input wire logic skip_pending,
    input wire logic [3:0] acc,
    input wire logic [2:0] d,
    input wire logic [3:0] x,
    input wire logic [3:0] y,
    input wire logic [1:0] z,
    input wire logic carry_flag,
    input wire logic [13:0] pc,
    input wire logic [2:0] stack_index
);
    wire logic live;
    assign live = op_valid && !busy && !skip_pending;
    wire logic [3:0] mem_seen;
    // A write still in flight is what a swap reads back
    assign mem_seen = (ram_we && ram_waddr == ram_raddr) ?
                      ram_wdata : ram_rdata;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_table;
        busy && rom_addr == {$past(op_page), $past(d), $past(acc)}
            && stack_index == $past(stack_index) + 3'h1;
    endsequence
    sequence s_back;
        !busy && pc == $past(pc, 3) + 14'h1
            && stack_index == $past(stack_index, 3);
    endsequence
    property p_lookup;
        live && op_code == nibble_core_pkg::rom_lookup_fetch
            |=> s_table ##1 busy ##1 s_back;
    endproperty
    a_lookup: assert property (p_lookup)
        else $error("lookup sequence wrong");
    property p_skip;
        op_valid && !busy && skip_pending |=> !busy && !skip_pending
            && pc == $past(pc) + 14'h1 && acc == $past(acc);
    endproperty
    a_skip: assert property (p_skip)
        else $error("nullified op had an effect");
    property p_szc;
        live && op_code == nibble_core_pkg::skip_if_carry_zero
            |=> skip_pending != $past(carry_flag);
    endproperty
    a_szc: assert property (p_szc)
        else $error("carry test skip wrong");
    property p_rar;
        live && op_code == nibble_core_pkg::rotate_right_thru_carry
            |=> acc == {$past(carry_flag), $past(acc[3:1])}
            && carry_flag == $past(acc[0]);
    endproperty
    a_rar: assert property (p_rar)
        else $error("rotate wrong");
    property p_inv;
        live && op_code == nibble_core_pkg::invert_acc |=> acc == ~$past(acc);
    endproperty
    a_inv: assert property (p_inv)
        else $error("invert wrong");
    property p_dread;
        live && op_code == nibble_core_pkg::read_d_to_acc
            |=> acc == {1'b0, $past(d)};
    endproperty
    a_dread: assert property (p_dread)
        else $error("d read wrong");
    property p_swap;
        live && op_code inside {nibble_core_pkg::acc_mem_swap,
            nibble_core_pkg::swap_then_dec, nibble_core_pkg::swap_then_inc}
            |=> ram_we && ram_wdata == $past(acc)
            && ram_waddr == $past(ram_raddr) && acc == $past(mem_seen);
    endproperty
    a_swap: assert property (p_swap)
        else $error("swap write wrong");
    property p_ptr;
        ram_raddr == {z, x, y};
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("data pointer wrong");
    property p_pc;
        rom_addr == pc;
    endproperty
    a_pc: assert property (p_pc)
        else $error("rom address wrong");
endmodule : nibble_core_checker
bind nibble_cpu_transfer_alu_ops nibble_core_checker i_nibble_core_checker (
    .clk, .rst, .op_valid, .op_code, .op_page, .ram_rdata, .ram_raddr,
    .ram_we, .ram_waddr, .ram_wdata, .rom_addr, .busy, .skip_pending, .acc,
    .d, .x, .y, .z, .carry_flag, .pc, .stack_index
);
`default_nettype wire

// File: dv/nibble_cpu_transfer_alu_ops_tb.sv
// Self-checking bench of the nibble execution core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module nibble_cpu_transfer_alu_ops_tb;
    typedef struct packed {
        nibble_core_pkg::op_t op;
        logic [3:0] imm, imm2, mem, acc, x, y;
        logic cy;
    } row_t;
    logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0;
    nibble_core_pkg::op_t op_code = nibble_core_pkg::op_nop;
    logic [3:0] op_imm = 4'h0, op_imm2 = 4'h0, ram_rdata = 4'h0;
    logic [6:0] op_page = 7'h00;
    logic [7:0] rom_rdata = 8'h00;
    logic [9:0] ram_raddr, ram_waddr;
    logic ram_we, busy, skip_pending, carry_flag;
    logic [3:0] ram_wdata, acc, b, x, y;
    logic [7:0] e;
    logic [2:0] d, stack_index;
    logic [1:0] z;
    logic [13:0] rom_addr, pc, pcx;
    int err_total = 0, compares = 0, cycles = 0;
    row_t rows [27] = '{
        '{nibble_core_pkg::load_pointer_xy, 4'h5, 4'hf, 4'h0, 4'h0, 4'h5, 4'hf, 1'b0},
        '{nibble_core_pkg::load_acc_immediate, 4'h9, 4'h0, 4'h0, 4'h9, 4'h5, 4'hf, 1'b0},
        '{nibble_core_pkg::add_acc_immediate, 4'h8, 4'h0, 4'h0, 4'h1, 4'h5, 4'hf, 1'b0},
        '{nibble_core_pkg::set_carry_op, 4'h0, 4'h0, 4'h0, 4'h1, 4'h5, 4'hf, 1'b1},
        '{nibble_core_pkg::add_mem_with_carry, 4'h0, 4'h0, 4'he, 4'h0, 4'h5, 4'hf, 1'b1},
        '{nibble_core_pkg::add_mem_to_acc, 4'h0, 4'h0, 4'hc, 4'hc, 4'h5, 4'hf, 1'b1},
        '{nibble_core_pkg::and_mem_to_acc, 4'h0, 4'h0, 4'h6, 4'h4, 4'h5, 4'hf, 1'b1},
        '{nibble_core_pkg::or_mem_to_acc, 4'h0, 4'h0, 4'h9, 4'hd, 4'h5, 4'hf, 1'b1},
        '{nibble_core_pkg::invert_acc, 4'h0, 4'h0, 4'h0, 4'h2, 4'h5, 4'hf, 1'b1},
        '{nibble_core_pkg::rotate_right_thru_carry, 4'h0, 4'h0, 4'h0, 4'h9, 4'h5, 4'hf, 1'b0},
        '{nibble_core_pkg::pointer_inc, 4'h0, 4'h0, 4'h0, 4'h9, 4'h5, 4'h0, 1'b0},
        '{nibble_core_pkg::pointer_dec, 4'h0, 4'h0, 4'h0, 4'h9, 4'h5, 4'hf, 1'b0},
        '{nibble_core_pkg::copy_acc_to_y, 4'h0, 4'h0, 4'h0, 4'h9, 4'h5, 4'h9, 1'b0},
        '{nibble_core_pkg::load_acc_immediate, 4'h3, 4'h0, 4'h0, 4'h3, 4'h5, 4'h9, 1'b0},
        '{nibble_core_pkg::copy_y_to_acc, 4'h0, 4'h0, 4'h0, 4'h9, 4'h5, 4'h9, 1'b0},
        '{nibble_core_pkg::mem_to_acc_load, 4'h3, 4'h0, 4'ha, 4'ha, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::load_pointer_bank, 4'h6, 4'h0, 4'h0, 4'ha, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::read_z_to_acc, 4'h0, 4'h0, 4'h0, 4'h2, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::load_acc_immediate, 4'hf, 4'h0, 4'h0, 4'hf, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::load_d_from_acc, 4'h0, 4'h0, 4'h0, 4'hf, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::read_d_to_acc, 4'h0, 4'h0, 4'h0, 4'h7, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::read_stack_index, 4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h9, 1'b0},
        '{nibble_core_pkg::swap_then_dec, 4'h1, 4'h0, 4'h4, 4'h4, 4'h7, 4'h8, 1'b0},
        '{nibble_core_pkg::swap_then_inc, 4'hf, 4'h0, 4'h9, 4'h9, 4'h8, 4'h9, 1'b0},
        '{nibble_core_pkg::acc_mem_swap, 4'h0, 4'h0, 4'h1, 4'h1, 4'h8, 4'h9, 1'b0},
        '{nibble_core_pkg::copy_b_to_acc, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h9, 1'b0},
        '{nibble_core_pkg::set_carry_op, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h9, 1'b1}
    };
    nibble_cpu_transfer_alu_ops i_nibble_cpu_transfer_alu_ops (
        .clk, .rst, .op_valid, .op_code, .op_imm, .op_imm2, .op_page,
        .ram_rdata, .rom_rdata, .ram_raddr, .ram_we, .ram_waddr, .ram_wdata,
        .rom_addr, .busy, .skip_pending, .acc, .b, .e, .d, .x, .y, .z,
        .carry_flag, .pc, .stack_index
    );
    always #50 clk = ~clk;
    task give_verdict;
        if (err_total == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            err_total++;
            give_verdict();
        end
    end
    task run_op(input nibble_core_pkg::op_t op, input logic [3:0] imm,
                input logic [3:0] imm2, input logic [3:0] mem);
        op_valid = 1'b1;
        op_code = op;
        op_imm = imm;
        op_imm2 = imm2;
        ram_rdata = mem;
        pcx = pcx + 14'h1;
        @(posedge clk);
        #1;
        `CHK(pc, pcx)
    endtask : run_op
    // Lookup with a refused op held up during the busy cycles
    task lookup(input logic [6:0] page, input logic [6:0] low,
                input logic [7:0] romv);
        op_valid = 1'b1;
        op_code = nibble_core_pkg::rom_lookup_fetch;
        op_page = page;
        rom_rdata = romv;
        @(posedge clk);
        #1;
        `CHK(rom_addr, {page, low})
        `CHK({busy, stack_index}, 4'h9)
        op_code = nibble_core_pkg::pointer_inc;
        @(posedge clk);
        #1;
        `CHK({b, acc}, romv)
        @(posedge clk);
        #1;
        pcx = pcx + 14'h1;
        `CHK({busy, stack_index, y, pc}, {8'h09, pcx})
        op_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : lookup
    // Pop of an unwritten stack slot: pc unknown, index and skip checked
    task pop_test(input nibble_core_pkg::op_t op, input logic [4:0] exp);
        op_valid = 1'b1;
        op_code = op;
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        `CHK({busy, skip_pending}, 2'h2)
        @(posedge clk);
        #1;
        `CHK({busy, stack_index, skip_pending}, exp)
    endtask : pop_test
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        `CHK({acc, pc, busy, skip_pending}, 20'h0)
        pcx = 14'h0;
        foreach (rows[i]) begin
            run_op(rows[i].op, rows[i].imm, rows[i].imm2, rows[i].mem);
            `CHK(acc, rows[i].acc)
            `CHK({x, y}, {rows[i].x, rows[i].y})
            `CHK(carry_flag, rows[i].cy)
        end
        run_op(nibble_core_pkg::load_acc_immediate, 4'h5, 4'h0, 4'h0);
        lookup(7'h2a, 7'h75, 8'h5c);
        run_op(nibble_core_pkg::pack_e_from_b_acc, 4'h0, 4'h0, 4'h0);
        `CHK(e, 8'h5c)
        lookup(7'h01, 7'h7c, 8'ha1);
        run_op(nibble_core_pkg::unpack_e_to_b_acc, 4'h0, 4'h0, 4'h0);
        `CHK({b, acc}, 8'h5c)
        run_op(nibble_core_pkg::clear_carry_op, 4'h0, 4'h0, 4'h0);
        run_op(nibble_core_pkg::skip_if_carry_zero, 4'h0, 4'h0, 4'h0);
        `CHK(skip_pending, 1'b1)
        run_op(nibble_core_pkg::load_acc_immediate, 4'h3, 4'h0, 4'h0);
        `CHK({acc, skip_pending}, 5'h18)
        run_op(nibble_core_pkg::skip_if_carry_zero, 4'h0, 4'h0, 4'h0);
        run_op(nibble_core_pkg::rom_lookup_fetch, 4'h0, 4'h0, 4'h0);
        `CHK({busy, stack_index}, 4'h0)
        run_op(nibble_core_pkg::skip_if_carry_zero, 4'h0, 4'h0, 4'h0);
        run_op(nibble_core_pkg::return_op, 4'h0, 4'h0, 4'h0);
        `CHK({busy, stack_index}, 4'h0)
        run_op(nibble_core_pkg::set_carry_op, 4'h0, 4'h0, 4'h0);
        run_op(nibble_core_pkg::skip_if_carry_zero, 4'h0, 4'h0, 4'h0);
        `CHK(skip_pending, 1'b0)
        pop_test(nibble_core_pkg::return_op, 5'h0e);
        rst = 1'b1;
        op_valid = 1'b0;
        @(posedge clk);
        #1 rst = 1'b0;
        `CHK({acc, pc, busy, skip_pending}, 20'h0)
        pop_test(nibble_core_pkg::return_skip_op, 5'h0f);
        give_verdict();
    end
endmodule : nibble_cpu_transfer_alu_ops_tb
`undef CHK
`default_nettype wire
